// >>> core/ecs_defs.svh
// Register map, reset values and serial framing constants of the scaling register bank
`ifndef ECS_DEFS_SVH
`define ECS_DEFS_SVH
`define ECS_ADDR_ADIV 7'h42
`define ECS_ADDR_RDIV 7'h43
`define ECS_ADDR_SDIV 7'h44
`define ECS_ADDR_ANUM 7'h45
`define ECS_ADDR_ADEN 7'h46
`define ECS_ADDR_RNUM 7'h47
`define ECS_ADDR_RDEN 7'h48
`define ECS_ADDR_RSV_LO 7'h49
`define ECS_ADDR_RSV_HI 7'h7D
`define ECS_ADDR_ONES 7'h7E
`define ECS_ADDR_VER 7'h7F
`define ECS_DIV_RST 8'h00
`define ECS_NUM_RST 13'h0000
`define ECS_DEN_RST 12'h03F
`define ECS_REV_RST 3'h0
`define ECS_ONES_RST 8'h00
`define ECS_CMD_WR_BIT 7
`define ECS_REV_MSB 15
`define ECS_REV_LSB 13
`define ECS_NUM_MSB 12
`define ECS_CNT_ZERO 5'h00
`define ECS_CMD_LAST 5'h07
`define ECS_BYTE_LAST 5'h07
`define ECS_WORD_LAST 5'h0F
`endif

// >>> core/ecs_pkg.sv
// Types shared by the scaling register bank
package ecs_pkg;
  typedef enum logic [1:0] {ecs_st_cmd, ecs_st_wr, ecs_st_rd, ecs_st_end} ecs_state_type;
endpackage

// >>> core/ecs_regs.sv
// Energy divider and pulse scaling register bank behind the serial port
`include "ecs_defs.svh"

// Behaviour
// [R1] An 8-bit read-write active energy divider register resets to zero.
// [R2] An 8-bit read-write reactive energy divider register resets to zero.
// [R3] An 8-bit read-write apparent energy divider register resets to zero.
// [R4] A 16-bit active pulse numerator register resets to zero and scales the active pulse rate.
// [R5] Bits 15, 14 and 13 of the active pulse numerator show reverse active power of phases A, B and C.
// [R6] A 12-bit active pulse denominator register resets to 0x3F.
// [R7] A 16-bit reactive pulse numerator register resets to zero and scales the reactive pulse rate.
// [R8] Bits 15 to 13 of the reactive pulse numerator show reverse reactive power, phase A highest.
// [R9] A 12-bit reactive pulse denominator register resets to 0x3F.
// [R10] After each serial register read the ones count register holds the number of one bits read; reading the count itself leaves it unchanged.
// [R11] Host writes never alter read-only registers or bits, and read-write registers take both.
// [R12] Addresses 0x49 to 0x7D are reserved with no function, and 0x7F holds an 8-bit die version.
// [R13] Each pulse output runs at its base rate times the numerator value bits over the denominator.
// [R14] The host reads the ones count right after a read and compares it with its own count.
module ecs_regs
  import ecs_pkg::*;
#(
  parameter logic [7:0] DIE_VERSION = 8'h5A, // Arbitrary value
  parameter int ACC_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_din,
  output logic spi_dout,
  output logic spi_dout_oe,
  input wire logic [2:0] active_reverse_phase,
  input wire logic [2:0] reactive_reverse_phase,
  input wire logic active_base_pulse,
  input wire logic reactive_base_pulse,
  output logic active_pulse_output,
  output logic reactive_pulse_output,
  output logic [7:0] active_energy_divider,
  output logic [7:0] reactive_energy_divider,
  output logic [7:0] apparent_energy_divider
);

  // Pin synchronisers; the third sclk stage only serves edge detection
  logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
  logic cs_s1_ff, cs_s2_ff;
  logic din_s1_ff, din_s2_ff;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      din_s1_ff <= 1'b0;
      din_s2_ff <= 1'b0;
    end else begin
      sclk_s1_ff <= spi_sclk;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      cs_s1_ff <= spi_cs_n;
      cs_s2_ff <= cs_s1_ff;
      din_s1_ff <= spi_din;
      din_s2_ff <= din_s1_ff;
    end
  end

  logic cs_act, sclk_fall, sclk_rise;
  assign cs_act = ~cs_s2_ff;
  assign sclk_fall = sclk_s3_ff & ~sclk_s2_ff;
  assign sclk_rise = ~sclk_s3_ff & sclk_s2_ff;

  // Register state
  logic [7:0] adiv_ff, rdiv_ff, sdiv_ff, ones_ff;
  logic [12:0] act_num_ff, react_num_ff;
  logic [11:0] act_den_ff, react_den_ff;
  logic [2:0] act_rev_ff, react_rev_ff;

  // Serial engine state
  ecs_state_type state_ff;
  logic [4:0] cnt_ff;
  logic [7:0] cmd_ff;
  logic [15:0] rx_ff, tx_ff, rd_val_ff;
  logic dout_ff;

  logic [7:0] nxt_cmd;
  logic [6:0] reg_addr;
  logic reg_wide, cmd_done, data_done, wr_commit, rd_done;
  logic [4:0] last_bit, nxt_cnt;
  logic [15:0] nxt_rx, wr_val, rd_mux, tx_load;
  logic rsv_hit;

  assign nxt_cmd = {cmd_ff[6:0], din_s2_ff};
  assign reg_addr = (state_ff == ecs_st_cmd) ? nxt_cmd[6:0] : cmd_ff[6:0];
  // Numerators and denominators travel as two bytes, all others as one
  assign reg_wide = (reg_addr >= `ECS_ADDR_ANUM) && (reg_addr <= `ECS_ADDR_RDEN);
  assign last_bit = reg_wide ? `ECS_WORD_LAST : `ECS_BYTE_LAST;
  assign cmd_done = sclk_fall && (state_ff == ecs_st_cmd) && (cnt_ff == `ECS_CMD_LAST);
  assign data_done = sclk_fall && ((state_ff == ecs_st_wr) || (state_ff == ecs_st_rd)) && (cnt_ff == last_bit);
  assign wr_commit = data_done && (state_ff == ecs_st_wr);
  assign rd_done = data_done && (state_ff == ecs_st_rd);
  assign nxt_cnt = (cmd_done || data_done) ? `ECS_CNT_ZERO : cnt_ff + 5'h01;
  assign nxt_rx = {rx_ff[14:0], din_s2_ff};
  assign wr_val = nxt_rx;
  assign rsv_hit = (reg_addr >= `ECS_ADDR_RSV_LO) && (reg_addr <= `ECS_ADDR_RSV_HI);

  // Reserved and unknown addresses read as zero
  assign rd_mux =
    (reg_addr == `ECS_ADDR_ADIV) ? {8'h00, adiv_ff} :
    (reg_addr == `ECS_ADDR_RDIV) ? {8'h00, rdiv_ff} :
    (reg_addr == `ECS_ADDR_SDIV) ? {8'h00, sdiv_ff} :
    (reg_addr == `ECS_ADDR_ANUM) ? {act_rev_ff, act_num_ff} : // [R5]
    (reg_addr == `ECS_ADDR_ADEN) ? {4'h0, act_den_ff} :
    (reg_addr == `ECS_ADDR_RNUM) ? {react_rev_ff, react_num_ff} : // [R8]
    (reg_addr == `ECS_ADDR_RDEN) ? {4'h0, react_den_ff} :
    (reg_addr == `ECS_ADDR_ONES) ? {8'h00, ones_ff} :
    (reg_addr == `ECS_ADDR_VER) ? {8'h00, DIE_VERSION} : // [R12]
    16'h0000; // [R12]
  assign tx_load = reg_wide ? rd_mux : {rd_mux[7:0], 8'h00};

  // Data is taken on falling sclk and shifted out on rising sclk, MSB first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= ecs_st_cmd;
      cnt_ff <= `ECS_CNT_ZERO;
      cmd_ff <= 8'h00;
      rx_ff <= 16'h0000;
      tx_ff <= 16'h0000;
      rd_val_ff <= 16'h0000;
      dout_ff <= 1'b0;
    end else if (!cs_act) begin
      state_ff <= ecs_st_cmd;
      cnt_ff <= `ECS_CNT_ZERO;
      dout_ff <= 1'b0;
    end else begin
      if (sclk_fall) begin
        cnt_ff <= nxt_cnt;
      end
      unique case (state_ff)
        ecs_st_cmd: begin
          if (cmd_done) begin
            state_ff <= nxt_cmd[`ECS_CMD_WR_BIT] ? ecs_st_wr : ecs_st_rd;
            tx_ff <= tx_load;
            rd_val_ff <= rd_mux;
          end
          if (sclk_fall) begin
            cmd_ff <= nxt_cmd;
          end
        end
        ecs_st_wr: begin
          if (sclk_fall) begin
            rx_ff <= nxt_rx;
          end
          if (data_done) begin
            state_ff <= ecs_st_end;
          end
        end
        ecs_st_rd: begin
          if (sclk_rise) begin
            dout_ff <= tx_ff[15];
            tx_ff <= {tx_ff[14:0], 1'b0};
          end
          if (data_done) begin
            state_ff <= ecs_st_end;
          end
        end
        ecs_st_end: begin
          cmd_ff <= cmd_ff;
        end
      endcase
    end
  end

  assign spi_dout = dout_ff;
  assign spi_dout_oe = cs_act && (state_ff == ecs_st_rd);

  // Write decode; read-only and reserved addresses have no strobe
  logic wr_adiv, wr_rdiv, wr_sdiv, wr_anum, wr_aden, wr_rnum, wr_rden;
  assign wr_adiv = wr_commit && (cmd_ff[6:0] == `ECS_ADDR_ADIV);
  assign wr_rdiv = wr_commit && (cmd_ff[6:0] == `ECS_ADDR_RDIV);
  assign wr_sdiv = wr_commit && (cmd_ff[6:0] == `ECS_ADDR_SDIV);
  assign wr_anum = wr_commit && (cmd_ff[6:0] == `ECS_ADDR_ANUM);
  assign wr_aden = wr_commit && (cmd_ff[6:0] == `ECS_ADDR_ADEN);
  assign wr_rnum = wr_commit && (cmd_ff[6:0] == `ECS_ADDR_RNUM);
  assign wr_rden = wr_commit && (cmd_ff[6:0] == `ECS_ADDR_RDEN);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      adiv_ff <= `ECS_DIV_RST; // [R1]
      rdiv_ff <= `ECS_DIV_RST; // [R2]
      sdiv_ff <= `ECS_DIV_RST; // [R3]
      act_num_ff <= `ECS_NUM_RST; // [R4]
      act_den_ff <= `ECS_DEN_RST; // [R6]
      react_num_ff <= `ECS_NUM_RST; // [R7]
      react_den_ff <= `ECS_DEN_RST; // [R9]
    end else begin
      if (wr_adiv) adiv_ff <= wr_val[7:0]; // [R1] [R11]
      if (wr_rdiv) rdiv_ff <= wr_val[7:0]; // [R2] [R11]
      if (wr_sdiv) sdiv_ff <= wr_val[7:0]; // [R3] [R11]
      // Polarity bits are status, so a write keeps only the value bits
      if (wr_anum) act_num_ff <= wr_val[`ECS_NUM_MSB:0]; // [R4] [R11]
      if (wr_aden) act_den_ff <= wr_val[11:0]; // [R6]
      if (wr_rnum) react_num_ff <= wr_val[`ECS_NUM_MSB:0]; // [R7] [R11]
      if (wr_rden) react_den_ff <= wr_val[11:0]; // [R9]
    end
  end

  // Polarity flags from the datapath, same clock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      act_rev_ff <= `ECS_REV_RST;
      react_rev_ff <= `ECS_REV_RST;
    end else begin
      act_rev_ff <= active_reverse_phase; // [R5]
      react_rev_ff <= reactive_reverse_phase; // [R8]
    end
  end

  // Reading the count itself leaves it alone so the host can fetch it after a read
  logic ones_upd;
  assign ones_upd = rd_done && (cmd_ff[6:0] != `ECS_ADDR_ONES);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ones_ff <= `ECS_ONES_RST;
    end else if (ones_upd) begin
      ones_ff <= 8'($countones(rd_val_ff)); // [R10]
    end
  end

  assign active_energy_divider = adiv_ff;
  assign reactive_energy_divider = rdiv_ff;
  assign apparent_energy_divider = sdiv_ff;

  // Rate scalers; a zero denominator stops the output
  // Limitation: when num exceeds den, base pulses must come no faster than one per num/den clocks
  logic [1:0] base_w, pulse_w;
  logic [1:0][12:0] num_w;
  logic [1:0][11:0] den_w;
  assign base_w = {reactive_base_pulse, active_base_pulse};
  assign num_w = {react_num_ff, act_num_ff};
  assign den_w = {react_den_ff, act_den_ff};

  for (genvar g = 0; g < 2; g++) begin : g_scale
    logic [ACC_W-1:0] acc_ff, nxt_acc;
    logic fire, pulse_ff;
    assign fire = (den_w[g] != 12'h000) && (acc_ff >= ACC_W'(den_w[g]));
    assign nxt_acc = acc_ff + (base_w[g] ? ACC_W'(num_w[g]) : {ACC_W{1'b0}})
      - (fire ? ACC_W'(den_w[g]) : {ACC_W{1'b0}}); // [R13]
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        acc_ff <= {ACC_W{1'b0}};
        pulse_ff <= 1'b0;
      end else begin
        acc_ff <= nxt_acc;
        pulse_ff <= fire; // [R13]
      end
    end
    assign pulse_w[g] = pulse_ff;
  end

  assign active_pulse_output = pulse_w[0];
  assign reactive_pulse_output = pulse_w[1];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_adiv_wr;
    wr_adiv |=> adiv_ff == $past(wr_val[7:0]);
  endproperty
  a_adiv_wr: assert property (p_adiv_wr) else $error("active divider write lost"); // [R1]
  property p_rdiv_wr;
    wr_rdiv |=> rdiv_ff == $past(wr_val[7:0]);
  endproperty
  a_rdiv_wr: assert property (p_rdiv_wr) else $error("reactive divider write lost"); // [R2]
  property p_sdiv_stable;
    !wr_sdiv |=> $stable(sdiv_ff);
  endproperty
  a_sdiv_stable: assert property (p_sdiv_stable) else $error("apparent divider changed"); // [R3]
  property p_anum_rev;
    (state_ff == ecs_st_end) && (cmd_ff[6:0] == `ECS_ADDR_ANUM) |-> rd_mux[15:13] == $past(active_reverse_phase);
  endproperty
  a_anum_rev: assert property (p_anum_rev) else $error("active polarity bits wrong"); // [R5]
  property p_rnum_rev;
    (state_ff == ecs_st_end) && (cmd_ff[6:0] == `ECS_ADDR_RNUM) |-> rd_mux[15:13] == $past(reactive_reverse_phase);
  endproperty
  a_rnum_rev: assert property (p_rnum_rev) else $error("reactive polarity bits wrong"); // [R8]
  property p_anum_wr;
    wr_anum |=> act_num_ff == $past(wr_val[12:0]);
  endproperty
  a_anum_wr: assert property (p_anum_wr) else $error("active numerator write lost"); // [R4]
  property p_rden_wr;
    wr_rden |=> react_den_ff == $past(wr_val[11:0]);
  endproperty
  a_rden_wr: assert property (p_rden_wr) else $error("reactive denominator write lost"); // [R9]
  property p_ones;
    ones_upd |=> ones_ff == 8'($countones($past(rd_val_ff)));
  endproperty
  a_ones: assert property (p_ones) else $error("ones count wrong"); // [R10]
  property p_ro_stable;
    wr_commit && (cmd_ff[6:0] == `ECS_ADDR_ONES) |=> $stable(ones_ff);
  endproperty
  a_ro_stable: assert property (p_ro_stable) else $error("read-only register written"); // [R11]
  property p_rsv;
    rsv_hit |-> rd_mux == 16'h0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved address not zero"); // [R12]
  property p_apulse;
    active_pulse_output |-> $past(act_den_ff) != 12'h000 && $past(g_scale[0].acc_ff) >= ACC_W'($past(act_den_ff));
  endproperty
  a_apulse: assert property (p_apulse) else $error("active pulse without cause"); // [R13]
  property p_aden_rst;
    $fell(rst) |-> act_den_ff == `ECS_DEN_RST && react_num_ff == `ECS_NUM_RST;
  endproperty
  a_aden_rst: assert property (@(posedge ref_clk) p_aden_rst) else $error("bad reset value"); // [R6] [R7]

  c_write: cover property (wr_commit);
  c_read: cover property (rd_done);
  c_ones_read: cover property (rd_done && cmd_ff[6:0] == `ECS_ADDR_ONES);
  c_apulse: cover property (active_pulse_output);

endmodule // ecs_regs

// >>> testbench/ecs_host.sv
// Host microcontroller model that drives the serial port of the scaling register bank
module ecs_host (
  input wire logic ref_clk,
  output logic spi_sclk = 1'b0,
  output logic spi_cs_n = 1'b1,
  output logic spi_din = 1'b0,
  input wire logic spi_dout,
  input wire logic spi_dout_oe,
  output logic rd_valid = 1'b0,
  output logic [15:0] rd_word = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // Five cycles a phase keeps a margin over the three-cycle pin synchronisers
  localparam int HALF = 5;
  logic in_frame = 1'b0;

  // A released data line toggles, so a stale bit is never mistaken for a driven one
  always @(posedge ref_clk) begin
    if (!in_frame) spi_din <= ~spi_din;
  end

  task automatic xfer(input logic [7:0] cmd, input int nbits, input logic [15:0] wdata);
    logic [23:0] sh;
    logic [15:0] got;
    int i;
    sh = {cmd, wdata << (16 - nbits)};
    got = 16'h0000;
    in_frame = 1'b1;
    @(posedge ref_clk);
    spi_cs_n <= 1'b0;
    repeat (HALF) @(posedge ref_clk);
    for (i = 0; i < 8 + nbits; i++) begin
      spi_sclk <= 1'b1;
      spi_din <= sh[23 - i];
      repeat (HALF) @(posedge ref_clk);
      // An undriven output reads as the inverse of the last bit
      if (i >= 8) got = {got[14:0], spi_dout_oe ? spi_dout : ~got[0]};
      spi_sclk <= 1'b0;
      repeat (HALF) @(posedge ref_clk);
    end
    spi_cs_n <= 1'b1;
    if (!cmd[7]) begin
      rd_word <= got;
      rd_valid <= 1'b1;
    end
    @(posedge ref_clk);
    rd_valid <= 1'b0;
    repeat (HALF) @(posedge ref_clk);
    in_frame = 1'b0;
  endtask
endmodule // ecs_host

// >>> testbench/tb.sv
// Self-checking bench for the scaling register bank driven by the host model
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] VER = 8'hA7; // Arbitrary value
  localparam int LIMIT = 60000;
  localparam logic [15:0] RST_V [7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h003F, 16'h0, 16'h003F};
  localparam logic [15:0] MASK [7] = '{16'h00FF, 16'h00FF, 16'h00FF, 16'h1FFF, 16'h0FFF, 16'h1FFF, 16'h0FFF};
  localparam logic [6:0] RSV [3] = '{7'h49, 7'h60, 7'h7D};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] act_rev = 3'h0;
  logic [2:0] rea_rev = 3'h0;
  logic act_base = 1'b0;
  logic rea_base = 1'b0;
  logic sclk, cs_n, din, dout, dout_oe, rd_valid, act_out, rea_out;
  logic [7:0] adiv, rdiv, sdiv;
  logic [15:0] rd_word, v;
  logic [15:0] exp_q [$];
  logic [15:0] shadow [7];
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int seed = 66279;
  // Pulse counts stay four-state so an unknown pulse output spoils the total
  logic [15:0] n_a = 16'h0000;
  logic [15:0] n_r = 16'h0000;
  logic [15:0] b_a, b_r;
  int a, r;

  ecs_regs #(.DIE_VERSION(VER), .ACC_W(16)) ecs_regs_i (.ref_clk(ref_clk), .rst(rst), .spi_sclk(sclk),
    .spi_cs_n(cs_n), .spi_din(din), .spi_dout(dout), .spi_dout_oe(dout_oe), .active_reverse_phase(act_rev),
    .reactive_reverse_phase(rea_rev), .active_base_pulse(act_base), .reactive_base_pulse(rea_base),
    .active_pulse_output(act_out), .reactive_pulse_output(rea_out), .active_energy_divider(adiv),
    .reactive_energy_divider(rdiv), .apparent_energy_divider(sdiv));
  ecs_host ecs_host_i (.ref_clk(ref_clk), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_din(din), .spi_dout(dout),
    .spi_dout_oe(dout_oe), .rd_valid(rd_valid), .rd_word(rd_word));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Read results are judged in issue order as the host model reports them
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    n_a <= n_a + {15'h0000, act_out};
    n_r <= n_r + {15'h0000, rea_out};
    if (rd_valid === 1'b1) check(rd_word, exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX);
    if (cyc == LIMIT) begin
      err_total++;
      tally_and_finish();
    end
  end

  function automatic int nb(input logic [6:0] ad);
    return (ad >= 7'h45 && ad <= 7'h48) ? 16 : 8;
  endfunction

  task automatic wr(input logic [6:0] ad, input logic [15:0] d);
    ecs_host_i.xfer({1'b1, ad}, nb(ad), d);
  endtask

  // Every read other than of the ones count is followed by a ones count read, as the host does to catch line errors
  task automatic rd(input logic [6:0] ad, input logic [15:0] e);
    exp_q.push_back(e);
    ecs_host_i.xfer({1'b0, ad}, nb(ad), 16'h0000);
    if (ad != 7'h7E) begin
      exp_q.push_back(16'($countones(e)));
      ecs_host_i.xfer(8'h7E, 8, 16'h0000);
    end
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      act_base <= 1'b1;
      rea_base <= 1'b1;
      @(posedge ref_clk);
      act_base <= 1'b0;
      rea_base <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
    repeat (10) @(posedge ref_clk);
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (5) @(posedge ref_clk);
    check({adiv, rdiv}, 16'h0000);
    check({8'h00, sdiv}, 16'h0000);
    rd(7'h7E, 16'h0000);
    for (a = 0; a < 7; a++) rd(7'h42 + 7'(a), RST_V[a]);
    for (r = 0; r < 2; r++) begin
      act_rev <= 3'($random(seed));
      rea_rev <= 3'($random(seed));
      for (a = 0; a < 7; a++) begin
        v = 16'($random(seed));
        shadow[a] = v & MASK[a];
        wr(7'h42 + 7'(a), v);
      end
      check({adiv, rdiv}, {shadow[0][7:0], shadow[1][7:0]});
      check({8'h00, sdiv}, shadow[2]);
      for (a = 0; a < 7; a++) begin
        v = a == 3 ? {act_rev, 13'h0} : a == 5 ? {rea_rev, 13'h0} : 16'h0;
        rd(7'h42 + 7'(a), shadow[a] | v);
      end
    end
    wr(7'h7E, 16'h00FF);
    wr(7'h7F, 16'h00FF);
    for (a = 0; a < 3; a++) wr(RSV[a], 16'h00FF);
    rd(7'h7F, {8'h00, VER});
    for (a = 0; a < 3; a++) rd(RSV[a], 16'h0000);
    wr(7'h7E, 16'h00FF);
    rd(7'h7E, 16'h0000);
    // Top numerator bits are set to show they take no part in scaling
    wr(7'h45, 16'hE003);
    wr(7'h46, 16'h0007);
    wr(7'h47, 16'h0005);
    wr(7'h48, 16'h0004);
    b_a = n_a;
    b_r = n_r;
    pulses(40);
    check(n_a - b_a, 16'(120 / 7));
    check(n_r - b_r, 16'(200 / 4));
    // A zero denominator must silence both outputs
    wr(7'h46, 16'h0000);
    wr(7'h48, 16'h0000);
    b_a = n_a;
    b_r = n_r;
    pulses(10);
    check(n_a - b_a, 16'h0000);
    check(n_r - b_r, 16'h0000);
    check(16'(exp_q.size()), 16'h0000);
    tally_and_finish();
  end
endmodule // tb
